// file: rtl/leam_regs.vh
/*
 * constants for the little-endian address munger: access widths, xor masks,
 * instruction kinds, machine state bit positions.
 * assumes inclusion by bare name from design files.
 */
`ifndef LEAM_REGS_VH
`define LEAM_REGS_VH

// ----------------------------------------------------------------
// access width codes
// ----------------------------------------------------------------
`define LEAM_W1        2'h0
`define LEAM_W2        2'h1
`define LEAM_W4        2'h2
`define LEAM_W8        2'h3

// ----------------------------------------------------------------
// low address xor masks
// ----------------------------------------------------------------
`define LEAM_X1        3'h7
`define LEAM_X2        3'h6
`define LEAM_X4        3'h4
`define LEAM_X8        3'h0

// ----------------------------------------------------------------
// access kinds
// ----------------------------------------------------------------
`define LEAM_K_SINGLE  2'h0
`define LEAM_K_STRING  2'h1
`define LEAM_K_MULTI   2'h2

// ----------------------------------------------------------------
// machine state bits, reset values and instruction step
// ----------------------------------------------------------------
`define LEAM_MSR_EM    0
`define LEAM_MSR_XE    1
`define LEAM_MSR_RST   2'h0
`define LEAM_INSN_STEP 32'h00000004
`define LEAM_PC_RST    32'h00000000

`endif

// file: rtl/leam_xor.v
/*
 * width-dependent low address xor.
 * assumes width code and mode are stable in the same cycle.
 */
`timescale 1ns/1ps
`include "leam_regs.vh"
module leam_xor
(
	input  wire        le_in,
	input  wire [1:0]  width_in,
	input  wire [31:0] addr_in,
	output reg  [31:0] addr_out
);
	reg [2:0] mask;
	always @*
	begin
		case (width_in)
			`LEAM_W1: mask = `LEAM_X1;
			`LEAM_W2: mask = `LEAM_X2;
			`LEAM_W4: mask = `LEAM_X4;
			default:  mask = `LEAM_X8;
		endcase
		// big-endian leaves the address alone
		if (!le_in)
			mask = `LEAM_X8;
		addr_out = {addr_in[31:3], addr_in[2:0] ^ mask};
	end
endmodule

// file: rtl/leam_align.v
/*
 * misalignment and little-endian exception check.
 * assumes the address is the unmodified effective address.
 */
`timescale 1ns/1ps
`include "leam_regs.vh"
module leam_align
#(
	parameter ALLOW_IN_DW = 0
)
(
	input  wire        le_in,
	input  wire [1:0]  width_in,
	input  wire [1:0]  kind_in,
	input  wire [31:0] addr_in,
	output reg         fault_out
);
	reg       mis;
	reg       span;
	reg [3:0] last;
	always @*
	begin
		// checked before the xor so the program view decides
		case (width_in)
			`LEAM_W1: mis = 1'b0;
			`LEAM_W2: mis = addr_in[0];
			`LEAM_W4: mis = |addr_in[1:0];
			default:  mis = |addr_in[2:0];
		endcase
		last = {1'b0, addr_in[2:0]} + ({2'h0, width_in} == 4'h3 ? 4'h7 :
			(4'h1 << width_in) - 4'h1);
		span = last[3];
		fault_out = 1'b0;
		if (le_in)
		begin
			if (kind_in == `LEAM_K_STRING)
				fault_out = 1'b1;
			else if (kind_in == `LEAM_K_MULTI)
				fault_out = 1'b1;
			else if (mis)
				// optional relaxation keeps faults only across doublewords
				fault_out = (ALLOW_IN_DW != 0) ? span : 1'b1;
		end
	end
endmodule

// file: rtl/leam_top.v
/*
 * little-endian address munger: data address path, fetch address path,
 * branch and link handling, endian mode state.
 * assumes a synchronous core pipeline driving one request per cycle and
 * memory that takes the presented address and byte width as given.
 */
`timescale 1ns/1ps
`include "leam_regs.vh"
module leam_top
#(
	parameter ALLOW_IN_DW = 0
)
(
	input  wire        clock_in,
	input  wire        rst_in,
	// machine state write
	input  wire        msr_we_in,
	input  wire [1:0]  msr_wdata_in,
	output wire [1:0]  msr_out,
	output wire        little_endian_active_out,
	// data path
	input  wire        dreq_in,
	input  wire        dwrite_in,
	input  wire [1:0]  dwidth_in,
	input  wire [1:0]  dkind_in,
	input  wire [31:0] dea_in,
	input  wire [63:0] dwdata_in,
	output reg         mreq_out,
	output reg         mwrite_out,
	output reg  [1:0]  mwidth_out,
	output reg  [31:0] maddr_out,
	output reg  [63:0] mwdata_out,
	output reg         align_exc_out,
	// instruction path
	input  wire        fetch_in,
	input  wire        branch_in,
	input  wire        branch_abs_in,
	input  wire        branch_link_in,
	input  wire [31:0] branch_val_in,
	input  wire        exc_in,
	input  wire [31:0] exc_vector_in,
	output reg  [31:0] pc_out,
	output reg  [31:0] faddr_out,
	output reg         freq_out,
	output reg  [31:0] link_out,
	output reg         link_we_out,
	output reg  [31:0] saved_pc_out
);
	// ----------------------------------------------------------------
	// endian state
	// ----------------------------------------------------------------
	reg  [1:0]  machine_state_register_q;
	wire        endian_mode_bit;
	wire        exception_endian_bit;
	assign endian_mode_bit = machine_state_register_q[`LEAM_MSR_EM];
	assign exception_endian_bit = machine_state_register_q[`LEAM_MSR_XE];
	assign msr_out = machine_state_register_q;
	assign little_endian_active_out = endian_mode_bit;

	always @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
			machine_state_register_q <= `LEAM_MSR_RST;
		else if (exc_in)
			// exception wins over a software write in the same cycle
			machine_state_register_q[`LEAM_MSR_EM] <= exception_endian_bit;
		else if (msr_we_in)
			machine_state_register_q <= msr_wdata_in;
	end

	// ----------------------------------------------------------------
	// data address path
	// ----------------------------------------------------------------
	wire [31:0] dmod;
	wire        dfault;

	leam_xor u_dxor
	(
		.le_in    (endian_mode_bit),
		.width_in (dwidth_in),
		.addr_in  (dea_in),
		.addr_out (dmod)
	);

	leam_align #(.ALLOW_IN_DW(ALLOW_IN_DW)) u_align
	(
		.le_in     (endian_mode_bit),
		.width_in  (dwidth_in),
		.kind_in   (dkind_in),
		.addr_in   (dea_in),
		.fault_out (dfault)
	);

	always @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			mreq_out      <= 1'b0;
			mwrite_out    <= 1'b0;
			mwidth_out    <= `LEAM_W1;
			maddr_out     <= `LEAM_PC_RST;
			mwdata_out    <= 64'h0000000000000000;
			align_exc_out <= 1'b0;
		end
		else
		begin
			// a faulting access never reaches memory
			mreq_out      <= dreq_in & ~dfault;
			mwrite_out    <= dwrite_in;
			mwidth_out    <= dwidth_in;
			maddr_out     <= dmod;
			mwdata_out    <= dwdata_in;
			align_exc_out <= dreq_in & dfault;
		end
	end

	// ----------------------------------------------------------------
	// instruction address path
	// ----------------------------------------------------------------
	reg  [31:0] pc_d;
	wire [31:0] pc_next_seq;
	wire [31:0] fmod;
	assign pc_next_seq = pc_out + `LEAM_INSN_STEP;

	always @*
	begin
		pc_d = pc_out;
		if (exc_in)
			pc_d = exc_vector_in;
		else if (branch_in)
			// displacement is between program-visible addresses
			pc_d = branch_abs_in ? branch_val_in : pc_out + branch_val_in;
		else if (fetch_in)
			pc_d = pc_next_seq;
	end

	// fetch uses the mode in force now; word xor is the only change.
	// instruction words pass through unswapped, stored big-endian.
	leam_xor u_fxor
	(
		.le_in    (endian_mode_bit),
		.width_in (`LEAM_W4),
		.addr_in  (pc_out),
		.addr_out (fmod)
	);

	always @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pc_out       <= `LEAM_PC_RST;
			faddr_out    <= `LEAM_PC_RST;
			freq_out     <= 1'b0;
			link_out     <= `LEAM_PC_RST;
			link_we_out  <= 1'b0;
			saved_pc_out <= `LEAM_PC_RST;
		end
		else
		begin
			pc_out      <= pc_d;
			faddr_out   <= fmod;
			freq_out    <= fetch_in & ~exc_in;
			link_we_out <= branch_in & branch_link_in & ~exc_in;
			if (branch_in && branch_link_in && !exc_in)
				link_out <= pc_next_seq;
			if (exc_in)
				saved_pc_out <= pc_out;
		end
	end
endmodule

// file: test/leam_top_monitor.sv
/* checker on the munger top ports.
   assumes bind to leam_top and one clock domain. */
`timescale 1ns/1ps
`include "leam_regs.vh"
module leam_top_monitor
(
	input wire        clock_in,
	input wire        rst_in,
	input wire [1:0]  msr_out,
	input wire        little_endian_active_out,
	input wire        dreq_in,
	input wire [1:0]  dwidth_in,
	input wire [1:0]  dkind_in,
	input wire [31:0] dea_in,
	input wire        mreq_out,
	input wire [1:0]  mwidth_out,
	input wire [31:0] maddr_out,
	input wire        align_exc_out,
	input wire        fetch_in,
	input wire        branch_in,
	input wire        branch_abs_in,
	input wire        branch_link_in,
	input wire [31:0] branch_val_in,
	input wire        exc_in,
	input wire [31:0] pc_out,
	input wire [31:0] faddr_out,
	input wire        freq_out,
	input wire [31:0] link_out,
	input wire        link_we_out
);
	// ----
	// port relations
	// ----
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);
	wire le = little_endian_active_out;
	a_byte_xor:
	assert property (dreq_in && le && dkind_in == `LEAM_K_SINGLE && dwidth_in == `LEAM_W1
		|=> mreq_out && maddr_out == ($past(dea_in) ^ 32'h00000007)) else $error("byte xor");
	a_be_plain:
	assert property (dreq_in && !le |=> mreq_out && !align_exc_out
		&& maddr_out == $past(dea_in) && mwidth_out == $past(dwidth_in)) else $error("be path");
	a_word_fault:
	assert property (dreq_in && le && dwidth_in == `LEAM_W4 && dea_in[2:0] == 3'h5
		|=> align_exc_out && !mreq_out) else $error("no misalign fault");
	a_kind_fault:
	assert property (dreq_in && le && dkind_in != `LEAM_K_SINGLE |=> align_exc_out)
		else $error("no string or multiple fault");
	a_fetch_step:
	assert property (fetch_in && !branch_in && !exc_in |=> pc_out == $past(pc_out) + 32'h00000004)
		else $error("fetch step");
	a_fetch_xor:
	assert property (freq_out && $stable(le) |-> faddr_out == ($past(pc_out) ^ {29'h0, le, 2'h0}))
		else $error("fetch address");
	a_rel_branch:
	assert property (branch_in && !branch_abs_in && !exc_in
		|=> pc_out == $past(pc_out) + $past(branch_val_in)) else $error("relative target");
	a_link_addr:
	assert property (branch_in && branch_link_in && !exc_in
		|=> link_we_out && link_out == $past(pc_out) + 32'h00000004) else $error("link value");
	a_exc_mode:
	assert property (exc_in |=> msr_out[0] == $past(msr_out[1])) else $error("exception mode");
endmodule
bind leam_top leam_top_monitor mon (.*);

// file: test/leam_mem_model.sv
/* byte memory on the far side of the munger.
   assumes stores only; no read data port exists to answer. */
`timescale 1ns/1ps
module leam_mem_model
(
	input wire        clock_in,
	input wire        mreq_in,
	input wire        mwrite_in,
	input wire [1:0]  mwidth_in,
	input wire [31:0] maddr_in,
	input wire [63:0] mwdata_in
);
	// ----
	// 64 bytes, address wraps
	// ----
	logic [7:0] mem_q [0:63];
	integer     n;
	integer     i;
	always @(posedge clock_in)
	begin
		n = 1 << mwidth_in;
		if (mreq_in && mwrite_in)
			for (i = 0; i < n; i++)
				mem_q[6'(maddr_in + i)] <= 8'(mwdata_in >> (8 * (n - 1 - i)));
	end
endmodule

// file: test/little_endian_address_munger_bench.sv
/* self-checking bench for the munger.
   assumes leam_top with the memory model on its memory port. */
`timescale 1ns/1ps
`include "leam_regs.vh"
module little_endian_address_munger_bench;
	logic clock_in = 0, rst_in = 1, msr_we_in = 0, dreq_in = 0, dwrite_in = 0;
	logic fetch_in = 0, branch_in = 0, branch_abs_in = 0, branch_link_in = 0, exc_in = 0;
	logic [1:0]  msr_wdata_in = 0, dwidth_in = 0, dkind_in = 0;
	logic [31:0] dea_in = 0, branch_val_in = 0, exc_vector_in = 32'h00000200;
	logic [63:0] dwdata_in = 0;
	wire  [1:0]  msr_out, mwidth_out;
	wire         little_endian_active_out, mreq_out, mwrite_out, align_exc_out;
	wire         freq_out, link_we_out;
	wire  [31:0] maddr_out, pc_out, faddr_out, link_out, saved_pc_out;
	wire  [63:0] mwdata_out;
	int          failures = 0;
	int          check_count = 0;
	logic [2:0]  m [4] = '{3'h7, 3'h6, 3'h4, 3'h0};
	leam_top dut (.*);
	leam_mem_model pm (.clock_in(clock_in), .mreq_in(mreq_out), .mwrite_in(mwrite_out),
		.mwidth_in(mwidth_out), .maddr_in(maddr_out), .mwdata_in(mwdata_out));
	// ----
	// shared tasks
	// ----
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task dop(input logic [1:0] w, input logic [1:0] k, input logic [31:0] a);
		@(negedge clock_in);
		{dreq_in, dwrite_in, dwidth_in, dkind_in, dea_in} = {2'h3, w, k, a};
		dwdata_in = 64'h0000000011121314;
		@(negedge clock_in);
		dreq_in = 0;
	endtask
	task ctl(input logic [4:0] c, input logic [31:0] v);
		@(negedge clock_in);
		{fetch_in, branch_in, branch_abs_in, branch_link_in, exc_in} = c;
		branch_val_in = v;
		@(negedge clock_in);
		{fetch_in, branch_in, branch_abs_in, branch_link_in, exc_in} = 5'h00;
	endtask
	task machine_state_register(input logic [1:0] v);
		@(negedge clock_in);
		{msr_we_in, msr_wdata_in} = {1'b1, v};
		@(negedge clock_in);
		msr_we_in = 0;
	endtask
	// ----
	// scenarios
	// ----
	task t_be;
		chk(msr_out, 2'h0);
		chk(little_endian_active_out, 1'b0);
		dop(`LEAM_W4, `LEAM_K_SINGLE, 32'h00000011);
		chk(align_exc_out, 1'b0);
		chk(maddr_out, 32'h00000011);
		chk(mwrite_out, 1'b1);
		chk(mwdata_out, 64'h0000000011121314);
	endtask
	task t_le_addr;
		machine_state_register(2'h3);
		chk(little_endian_active_out, 1'b1);
		for (int w = 0; w < 4; w++)
		begin
			dop(w[1:0], `LEAM_K_SINGLE, 32'h00000020);
			chk(maddr_out, {29'h4, m[w]});
			chk(mwidth_out, w[1:0]);
		end
		dop(`LEAM_W4, `LEAM_K_SINGLE, 32'h00000000);
		@(negedge clock_in);
		chk(pm.mem_q[7], 8'h14);
		chk(pm.mem_q[4], 8'h11);
	endtask
	task t_le_fault;
		dop(`LEAM_W4, `LEAM_K_SINGLE, 32'h00000025);
		chk({align_exc_out, mreq_out}, 2'h2);
		dop(`LEAM_W2, `LEAM_K_SINGLE, 32'h00000021);
		chk(align_exc_out, 1'b1);
		dop(`LEAM_W4, `LEAM_K_STRING, 32'h00000020);
		chk(align_exc_out, 1'b1);
		dop(`LEAM_W4, `LEAM_K_MULTI, 32'h00000020);
		chk(align_exc_out, 1'b1);
	endtask
	task t_flow;
		ctl(5'h10, 0);
		chk({pc_out, faddr_out}, {32'h4, 32'h4});
		chk(freq_out, 1'b1);
		ctl(5'h10, 0);
		chk({pc_out, faddr_out}, {32'h8, 32'h0});
		ctl(5'h08, 32'h00000010);
		chk(pc_out, 32'h00000018);
		ctl(5'h0E, 32'h00000100);
		chk(pc_out, 32'h00000100);
		chk(link_out, 32'h0000001C);
		chk(link_we_out, 1'b1);
		ctl(5'h10, 0);
		chk(faddr_out, 32'h00000104);
		machine_state_register(2'h1);
		ctl(5'h01, 0);
		chk({pc_out, msr_out}, {32'h200, 2'h0});
		chk(saved_pc_out, 32'h00000104);
	endtask
	task wrap_up;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		forever #25 clock_in = ~clock_in;
	end
	initial
	begin
		// ample margin: the sequence needs under 100 cycles
		#100000;
		failures++;
		wrap_up;
	end
	initial
	begin
		repeat (20) @(negedge clock_in);
		rst_in = 0;
		t_be;
		t_le_addr;
		t_le_fault;
		t_flow;
		wrap_up;
	end
endmodule
